// file: hdl/node_cfg_pkg.sv
// Package for the node configuration register bank: offsets, fields,
// reset values and the carrier structs for configuration accesses and clock-generator settings.
// Assumes one clock domain and 8-bit register numbers.
package node_cfg_pkg;
   // Register numbers
   localparam logic [7:0] REG_DEVICE_IDENTIFICATION = 8'h00;
   localparam logic [7:0] REG_SWITCH_DESCRIPTION = 8'h01;
   localparam logic [7:0] REG_SWITCH_CONFIGURATION = 8'h04;
   localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
   localparam logic [7:0] REG_CLOCK_GENERATOR_SETTINGS = 8'h06;
   localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
   localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
   localparam logic [7:0] REG_TEST_PORT_DEVICE_ID = 8'h09;
   localparam logic [7:0] REG_TEST_PORT_USER_CODE = 8'h0a;
   localparam logic [7:0] REG_ROUTE_DIRECTIONS_LOW = 8'h0c;
   localparam logic [7:0] REG_ROUTE_DIRECTIONS_HIGH = 8'h0d;
   localparam logic [7:0] REG_DEBUG_PIN_CONFIG_TILE0 = 8'h10;
   localparam logic [7:0] REG_DEBUG_PIN_CONFIG_TILE1 = 8'h11;
   localparam logic [7:0] REG_DEBUG_EVENT_SOURCE = 8'h1f;
   localparam logic [7:0] REG_LINK_STATUS_DIRECTION = 8'h20;
   localparam logic [7:0] REG_CORE_LINK_STATUS = 8'h40;
   localparam logic [7:0] REG_LINK_CONFIG_INIT = 8'h80;
   localparam logic [7:0] REG_STATIC_LINK_CONFIG = 8'ha0;

   // Switch configuration fields
   localparam int SWCFG_WRITE_LOCK_BIT = 31;
   localparam int SWCFG_CLKGEN_LOCK_BIT = 8;
   localparam int SWCFG_HEADER_BIT = 0;

   // Clock-generator settings fields
   localparam int CLKGEN_NO_RESET_BIT = 31;
   localparam int CLKGEN_NO_RELOCK_BIT = 30;
   localparam int CLKGEN_BYPASS_BIT = 29;
   localparam int CLKGEN_TEST_BOOT_BIT = 28;
   localparam int CLKGEN_OUT_DIV_HI = 25;
   localparam int CLKGEN_OUT_DIV_LO = 23;
   localparam int CLKGEN_FB_MUL_HI = 20;
   localparam int CLKGEN_FB_MUL_LO = 8;
   localparam int CLKGEN_IN_DIV_HI = 6;
   localparam int CLKGEN_IN_DIV_LO = 0;
   // Bits that hold state; the rest are reserved
   localparam logic [31:0] CLKGEN_WRITABLE_MASK = 32'hf39f_ff7f;

   // Identification fields
   localparam int IDENT_BOOT_PINS_LO = 16;
   localparam int IDENT_REVISION_LO = 8;
   localparam int IDENT_VERSION_LO = 0;

   // Reset values
   localparam logic [31:0] CLKGEN_RESET = 32'h0000_0000;
   localparam logic [15:0] NODE_ID_RESET = 16'h0000;
   localparam logic [15:0] SWITCH_DIV_RESET = 16'h0000;
   localparam logic [15:0] REF_DIV_RESET = 16'h0003;

   // One configuration access from the switch network
   typedef struct packed {
      logic write;
      logic [7:0] number;
      logic [31:0] data;
   } cfg_request_t;

   // Clock-generator settings handed to the clock logic
   typedef struct packed {
      logic no_relock;
      logic bypass;
      logic test_boot;
      logic [2:0] out_div;
      logic [12:0] fb_mul;
      logic [6:0] in_div;
   } clkgen_settings_t;
endpackage

// file: hdl/node_config_registers.sv
// Node configuration register bank of the system switch.
// Assumes configuration accesses arrive from the switch network as
// one-cycle requests on ref_clk, and that the boot pins are stable at reset.
// A write refused by a lock is still answered, so software sees no error;
// it must read the register back to learn whether the write landed.
//
// Summary of operation
// R01: Registers reached only by configuration accesses
// R02: Bit 31 of configuration locks control writes
// R03: Bit 8 of configuration locks clock settings
// R04: Bit 0 selects header width, resets 0
// R05: Node identifier is 16 writable bits
// R06: Clock settings write resets the tile
// R07: Written bit 31 set suppresses the reset
// R08: Bit 30 skips waiting for relock
// R09: Bit 29 bypasses the frequency multiplier
// R10: Bit 28 selects test port boot
// R11: Output divider in bits 25:23
// R12: Feedback multiplier in bits 20:8
// R13: Input divider in bits 6:0
// R14: Multiplied clock drives I/O, processor, switch
// R15: Switch clock divider is 16 writable bits
// R16: Boot pins captured at reset, held after
// R17: Identification gives revision and version, read-only
// R18: Description gives link and processor counts
// R19: Blocked writes dropped, reserved bits read zero
`timescale 1ns/10ps
`default_nettype none
module node_config_registers #(
   parameter logic [7:0] SWITCH_REVISION = 8'h01, // Arbitrary value
   parameter logic [7:0] SWITCH_VERSION = 8'h01, // Arbitrary value
   parameter logic [7:0] LINK_COUNT = 8'h08,
   parameter logic [7:0] SWITCH_CORES = 8'h02,
   parameter logic [7:0] DEVICE_CORES = 8'h02,
   parameter logic [31:0] TEST_DEVICE_ID = 32'h0000_0001, // Arbitrary value
   parameter logic [31:0] TEST_USER_CODE = 32'h0000_0000 // Arbitrary value
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Configuration access from the switch network
   input wire logic cfg_valid,
   input wire node_cfg_pkg::cfg_request_t cfg_request,
   output logic cfg_ack,
   output logic [31:0] cfg_read_data,
   // Boot-control pin levels
   input wire logic [7:0] boot_select_pins,
   // Clock generator and switch controls
   output node_cfg_pkg::clkgen_settings_t clkgen_settings,
   output logic clkgen_update,
   output logic tile_reset_request,
   output logic one_byte_headers,
   output logic [15:0] node_identifier,
   output logic [15:0] switch_clock_divider,
   output logic [15:0] reference_clock_divider
);
   import node_cfg_pkg::*;

   logic write_lock;
   logic clkgen_lock;
   logic [31:0] clkgen_reg;
   logic [7:0] boot_pins_held;
   logic write_strobe;
   logic clkgen_write;

   // Writes allowed only when not locked; the lock bit itself stays
   // writable so software can unlock again through configuration writes
   function automatic logic write_allowed(input logic [7:0] number,
                                          input logic lock);
      write_allowed = !lock || number == REG_SWITCH_CONFIGURATION;
   endfunction

   // Only configuration writes from the network reach the bank
   assign write_strobe = cfg_valid && cfg_request.write; // [R01]
   assign clkgen_write = write_strobe &&
      cfg_request.number == REG_CLOCK_GENERATOR_SETTINGS &&
      write_allowed(cfg_request.number, write_lock) &&
      !clkgen_lock; // [R02] [R03]

   // Switch configuration: two locks and the header width
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         write_lock <= 1'b0;
         clkgen_lock <= 1'b0;
         one_byte_headers <= 1'b0; // [R04]
      end else if (write_strobe &&
                   cfg_request.number == REG_SWITCH_CONFIGURATION) begin
         write_lock <= cfg_request.data[SWCFG_WRITE_LOCK_BIT]; // [R02]
         clkgen_lock <= cfg_request.data[SWCFG_CLKGEN_LOCK_BIT]; // [R03]
         one_byte_headers <= cfg_request.data[SWCFG_HEADER_BIT]; // [R04]
      end
   end

   // Node identifier and switch clock divider, dropped when locked
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         node_identifier <= NODE_ID_RESET; // [R05]
         switch_clock_divider <= SWITCH_DIV_RESET; // [R15]
         reference_clock_divider <= REF_DIV_RESET;
      end else if (write_strobe &&
                   write_allowed(cfg_request.number, write_lock)) begin
         // Blocked writes simply fall through here [R19]
         if (cfg_request.number == REG_NODE_IDENTIFIER)
            node_identifier <= cfg_request.data[15:0]; // [R05]
         if (cfg_request.number == REG_SWITCH_CLOCK_DIVIDER)
            switch_clock_divider <= cfg_request.data[15:0]; // [R15]
         if (cfg_request.number == REG_REFERENCE_CLOCK_DIVIDER)
            reference_clock_divider <= cfg_request.data[15:0];
      end
   end

   // Clock-generator settings; reserved bits never stored
   always_ff @(posedge ref_clk) begin
      if (reset)
         clkgen_reg <= CLKGEN_RESET;
      else if (clkgen_write)
         clkgen_reg <= cfg_request.data & CLKGEN_WRITABLE_MASK; // [R19]
   end

   // Update pulse follows each accepted write; tile reset request only those with bit 31 clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         clkgen_update <= 1'b0;
         tile_reset_request <= 1'b0;
      end else begin
         clkgen_update <= clkgen_write; // [R07]
         tile_reset_request <= clkgen_write &&
            !cfg_request.data[CLKGEN_NO_RESET_BIT]; // [R06] [R07]
      end
   end

   // Fields handed to the clock generator, which feeds I/O, cores, switch
   always_comb begin
      clkgen_settings.no_relock = clkgen_reg[CLKGEN_NO_RELOCK_BIT]; // [R08]
      clkgen_settings.bypass = clkgen_reg[CLKGEN_BYPASS_BIT]; // [R09] [R14]
      clkgen_settings.test_boot = clkgen_reg[CLKGEN_TEST_BOOT_BIT]; // [R10]
      clkgen_settings.out_div =
         clkgen_reg[CLKGEN_OUT_DIV_HI:CLKGEN_OUT_DIV_LO]; // [R11]
      clkgen_settings.fb_mul =
         clkgen_reg[CLKGEN_FB_MUL_HI:CLKGEN_FB_MUL_LO]; // [R12]
      clkgen_settings.in_div =
         clkgen_reg[CLKGEN_IN_DIV_HI:CLKGEN_IN_DIV_LO]; // [R13]
   end

   // Boot pins followed while reset is held and frozen at release, so even
   // a read in the very first cycle after reset sees the captured levels
   always_ff @(posedge ref_clk) begin
      if (reset)
         boot_pins_held <= boot_select_pins; // [R16]
   end

   // Read path: every access answered one cycle later
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_ack <= 1'b0;
         cfg_read_data <= 32'h0000_0000;
      end else begin
         cfg_ack <= cfg_valid;
         if (cfg_valid && !cfg_request.write) begin
            unique case (cfg_request.number)
               REG_DEVICE_IDENTIFICATION:
                  cfg_read_data <= {8'h00, boot_pins_held,
                     SWITCH_REVISION, SWITCH_VERSION}; // [R16] [R17]
               REG_SWITCH_DESCRIPTION:
                  cfg_read_data <= {8'h00, LINK_COUNT, SWITCH_CORES,
                     DEVICE_CORES}; // [R18]
               REG_SWITCH_CONFIGURATION:
                  cfg_read_data <= {write_lock, 22'h0, clkgen_lock,
                     7'h00, one_byte_headers}; // [R19]
               REG_NODE_IDENTIFIER:
                  cfg_read_data <= {16'h0000, node_identifier}; // [R05]
               REG_CLOCK_GENERATOR_SETTINGS:
                  cfg_read_data <= clkgen_reg;
               REG_SWITCH_CLOCK_DIVIDER:
                  cfg_read_data <= {16'h0000, switch_clock_divider};
               REG_REFERENCE_CLOCK_DIVIDER:
                  cfg_read_data <= {16'h0000, reference_clock_divider};
               REG_TEST_PORT_DEVICE_ID:
                  cfg_read_data <= TEST_DEVICE_ID;
               REG_TEST_PORT_USER_CODE:
                  cfg_read_data <= TEST_USER_CODE;
               // Fields of the other registers live elsewhere
               default:
                  cfg_read_data <= 32'h0000_0000;
            endcase
         end else begin
            cfg_read_data <= 32'h0000_0000;
         end
      end
   end

   // Checks, all on ref_clk and silenced while reset is held,
   // since every register is being forced then

   // Every access is answered exactly one cycle later
   ack_follows_a: assert property (@(posedge ref_clk) // [R01]
      disable iff (reset)
      cfg_valid |=> cfg_ack)
      else $error("access not answered");

   // And never without an access
   ack_spurious_a: assert property (@(posedge ref_clk) // [R01]
      disable iff (reset)
      !cfg_valid |=> !cfg_ack)
      else $error("answer without access");

   // Writes return no data
   write_data_a: assert property (@(posedge ref_clk) // [R01]
      disable iff (reset)
      cfg_valid && cfg_request.write
      |=> cfg_read_data == 32'h0000_0000)
      else $error("write returned data");

   // A locked bank leaves the node identifier alone
   lock_switch_cfg_a: assert property (@(posedge ref_clk) // [R02]
      disable iff (reset)
      write_strobe && write_lock &&
      cfg_request.number == REG_NODE_IDENTIFIER
      |=> $stable(node_identifier))
      else $error("node identifier changed while locked");

   // And the switch clock divider
   lock_switch_div_a: assert property (@(posedge ref_clk) // [R02]
      disable iff (reset)
      write_strobe && write_lock &&
      cfg_request.number == REG_SWITCH_CLOCK_DIVIDER
      |=> $stable(switch_clock_divider))
      else $error("switch divider changed while locked");

   // The control lock covers the clock settings too; no pulse may
   // leak out of a dropped write
   lock_all_clkgen_a: assert property (@(posedge ref_clk) // [R02]
      disable iff (reset)
      write_strobe && write_lock &&
      cfg_request.number == REG_CLOCK_GENERATOR_SETTINGS
      |=> $stable(clkgen_reg) && !clkgen_update)
      else $error("clock settings taken under control lock");

   // Watched at the register, not the strobe, so a broken strobe
   // is caught as well
   lock_clkgen_a: assert property (@(posedge ref_clk) // [R03]
      disable iff (reset)
      write_strobe && clkgen_lock &&
      cfg_request.number == REG_CLOCK_GENERATOR_SETTINGS
      |=> $stable(clkgen_reg) && !clkgen_update)
      else $error("clock settings written while locked");

   // Header width follows bit 0 of each configuration write
   header_width_a: assert property (@(posedge ref_clk) // [R04]
      disable iff (reset)
      write_strobe && cfg_request.number == REG_SWITCH_CONFIGURATION
      |=> one_byte_headers == $past(cfg_request.data[0]))
      else $error("header width not taken");

   // An unlocked identifier write lands in full
   node_id_write_a: assert property (@(posedge ref_clk) // [R05]
      disable iff (reset)
      write_strobe && !write_lock &&
      cfg_request.number == REG_NODE_IDENTIFIER
      |=> node_identifier == $past(cfg_request.data[15:0]))
      else $error("node identifier not written");

   // The upper half of the identifier reads as zero
   node_id_read_a: assert property (@(posedge ref_clk) // [R05]
      disable iff (reset)
      cfg_valid && !cfg_request.write &&
      cfg_request.number == REG_NODE_IDENTIFIER
      |=> cfg_read_data == {16'h0000, $past(node_identifier)})
      else $error("node identifier read wrong");

   // A settings write asks for a tile reset unless bit 31 is set
   tile_reset_a: assert property (@(posedge ref_clk) // [R06]
      disable iff (reset)
      clkgen_write && !cfg_request.data[CLKGEN_NO_RESET_BIT]
      |=> tile_reset_request && clkgen_update)
      else $error("tile reset missing");

   // Neither pulse comes without an accepted write just before
   pulse_origin_a: assert property (@(posedge ref_clk) // [R06]
      disable iff (reset)
      !clkgen_write |=> !clkgen_update && !tile_reset_request)
      else $error("clock pulse without a write");

   // Bit 31 keeps the update but drops the reset
   no_reset_a: assert property (@(posedge ref_clk) // [R07]
      disable iff (reset)
      clkgen_write && cfg_request.data[CLKGEN_NO_RESET_BIT]
      |=> !tile_reset_request && clkgen_update)
      else $error("reset not suppressed");

   // Single-bit controls land where the clock logic expects them
   bypass_field_a: assert property (@(posedge ref_clk) // [R08] [R09] [R10]
      disable iff (reset)
      clkgen_write |=> clkgen_settings.bypass == $past(cfg_request.data[29])
         && clkgen_settings.no_relock == $past(cfg_request.data[30])
         && clkgen_settings.test_boot == $past(cfg_request.data[28]))
      else $error("bypass, relock or boot source wrong");

   // Divider fields pass through unshifted
   divider_fields_a: assert property (@(posedge ref_clk) // [R11] [R12] [R13]
      disable iff (reset)
      clkgen_write |=> clkgen_settings.fb_mul == $past(cfg_request.data[20:8])
         && clkgen_settings.in_div == $past(cfg_request.data[6:0])
         && clkgen_settings.out_div == $past(cfg_request.data[25:23]))
      else $error("divider fields wrong");

   // An unlocked switch divider write lands in full
   switch_div_a: assert property (@(posedge ref_clk) // [R15]
      disable iff (reset)
      write_strobe && !write_lock &&
      cfg_request.number == REG_SWITCH_CLOCK_DIVIDER
      |=> switch_clock_divider == $past(cfg_request.data[15:0]))
      else $error("switch divider not written");

   // Its upper half reads as zero
   switch_div_read_a: assert property (@(posedge ref_clk) // [R15]
      disable iff (reset)
      cfg_valid && !cfg_request.write &&
      cfg_request.number == REG_SWITCH_CLOCK_DIVIDER
      |=> cfg_read_data == {16'h0000, $past(switch_clock_divider)})
      else $error("switch divider read wrong");

   // Pins seen during reset are what the first cycle after holds
   boot_capture_a: assert property (@(posedge ref_clk) // [R16]
      disable iff (reset)
      $past(reset) |-> boot_pins_held == $past(boot_select_pins))
      else $error("boot pins not captured");

   // From then on they never move
   boot_hold_a: assert property (@(posedge ref_clk) // [R16]
      disable iff (reset)
      !$past(reset) |-> $stable(boot_pins_held))
      else $error("boot pins changed");

   // Identification read gives pins, revision and version
   ident_read_a: assert property (@(posedge ref_clk) // [R16] [R17]
      disable iff (reset)
      cfg_valid && !cfg_request.write &&
      cfg_request.number == REG_DEVICE_IDENTIFICATION
      |=> cfg_ack && cfg_read_data == {8'h00, boot_pins_held,
         SWITCH_REVISION, SWITCH_VERSION})
      else $error("identification read wrong");

   // Description read gives the link and processor counts
   descr_read_a: assert property (@(posedge ref_clk) // [R18]
      disable iff (reset)
      cfg_valid && !cfg_request.write &&
      cfg_request.number == REG_SWITCH_DESCRIPTION
      |=> cfg_read_data == {8'h00, LINK_COUNT, SWITCH_CORES, DEVICE_CORES})
      else $error("description read wrong");

   // Configuration reads show only the three live bits
   cfg_reserved_a: assert property (@(posedge ref_clk) // [R19]
      disable iff (reset)
      cfg_valid && !cfg_request.write &&
      cfg_request.number == REG_SWITCH_CONFIGURATION
      |=> cfg_read_data[30:9] == 22'h0 && cfg_read_data[7:1] == 7'h00)
      else $error("configuration reserved bits set");

   // Settings reads show nothing in the reserved bits
   settings_read_a: assert property (@(posedge ref_clk) // [R19]
      disable iff (reset)
      cfg_valid && !cfg_request.write &&
      cfg_request.number == REG_CLOCK_GENERATOR_SETTINGS
      |=> (cfg_read_data & ~CLKGEN_WRITABLE_MASK) == 32'h0000_0000)
      else $error("settings reserved bits read set");

   // Reserved clock-generator bits are never stored
   reserved_zero_a: assert property (@(posedge ref_clk) // [R19]
      disable iff (reset)
      (clkgen_reg & ~CLKGEN_WRITABLE_MASK) == 32'h0000_0000)
      else $error("reserved clock bits set");

   // Main scenarios worth seeing at least once
   clkgen_write_c: cover property (@(posedge ref_clk) clkgen_write);
   locked_write_c: cover property (@(posedge ref_clk)
      write_strobe && write_lock);
   tile_reset_c: cover property (@(posedge ref_clk) tile_reset_request);
   locked_clkgen_c: cover property (@(posedge ref_clk)
      write_strobe && clkgen_lock &&
      cfg_request.number == REG_CLOCK_GENERATOR_SETTINGS);
   suppressed_reset_c: cover property (@(posedge ref_clk)
      clkgen_write && cfg_request.data[CLKGEN_NO_RESET_BIT]);
endmodule // node_config_registers
`default_nettype wire

// file: verification/cfg_access_master.sv
// Model of a processor tile issuing configuration accesses to the bank.
// Assumes callers enter access() just after a falling edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
module cfg_access_master (
   // Clock
   input wire logic ref_clk,
   // Access port of the register bank
   output var logic cfg_valid,
   output var node_cfg_pkg::cfg_request_t cfg_request,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_read_data
);
   import node_cfg_pkg::*;

   // Quiet bus until the first access
   initial begin
      cfg_valid = 1'b0;
      cfg_request = '0;
   end

   // One access, answer taken one cycle later; valid is left up so the
   // next call can follow back to back without a double assignment
   task automatic access(input logic write, input logic [7:0] number,
         input logic [31:0] data, output logic [31:0] read_data,
         output logic ack);
      cfg_valid = 1'b1;
      cfg_request = '{write, number, data}; // Relock skip passed as given
      @(negedge ref_clk);
      ack = cfg_ack;
      read_data = cfg_read_data;
   endtask

   // Release; request lines show the inverse of the last word so a stale
   // value can never pass for a fresh one
   task automatic release_bus();
      cfg_valid = 1'b0;
      cfg_request = ~cfg_request;
   endtask
endmodule // cfg_access_master
`default_nettype wire

// file: verification/node_config_registers_test.sv
// Self-checking bench for the node configuration register bank.
// Assumes the access model drives the request port at falling edges.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, exp, got) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      $display("unexpected %s expected %h seen %h", what, exp, got); \
      bad_count++; \
   end \
end
module node_config_registers_test;
   import node_cfg_pkg::*;
   // Identity values are arbitrary; counts differ to catch swapped fields
   localparam logic [7:0] REV = 8'h5a;
   localparam logic [7:0] VER = 8'h3c;
   localparam logic [7:0] LINKS = 8'h04;
   localparam logic [7:0] SW_CORES = 8'h02;
   localparam logic [7:0] DEV_CORES = 8'h06;
   localparam logic [7:0] BOOT = 8'ha5;
   localparam logic [31:0] IDENT = {8'h00, BOOT, REV, VER};
   typedef struct packed {
      logic write;
      logic [7:0] number;
      logic [31:0] data;
      logic [31:0] expect_data;
   } row_t;
   logic ref_clk;
   logic reset;
   logic cfg_valid;
   cfg_request_t cfg_request;
   logic cfg_ack;
   logic [31:0] cfg_read_data;
   logic [7:0] boot_select_pins;
   clkgen_settings_t clkgen_settings;
   logic clkgen_update;
   logic tile_reset_request;
   logic one_byte_headers;
   logic [15:0] node_identifier;
   logic [15:0] switch_clock_divider;
   logic [15:0] reference_clock_divider;
   int bad_count = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic ack;
   // Ordinary accesses, back to back, with the read data each should give
   row_t rows [13] = '{
      '{1'b0, REG_DEVICE_IDENTIFICATION, 32'h0, IDENT},
      '{1'b0, REG_SWITCH_DESCRIPTION, 32'h0,
        {8'h00, LINKS, SW_CORES, DEV_CORES}},
      '{1'b1, REG_NODE_IDENTIFIER, 32'hffff_1234, 32'h0},
      '{1'b0, REG_NODE_IDENTIFIER, 32'h0, 32'h0000_1234},
      '{1'b1, REG_SWITCH_CLOCK_DIVIDER, 32'habcd_8001, 32'h0},
      '{1'b0, REG_SWITCH_CLOCK_DIVIDER, 32'h0, 32'h0000_8001},
      '{1'b1, REG_DEVICE_IDENTIFICATION, 32'hffff_ffff, 32'h0},
      '{1'b0, REG_DEVICE_IDENTIFICATION, 32'h0, IDENT},
      '{1'b1, REG_SWITCH_CONFIGURATION, 32'h7fff_feff, 32'h0},
      '{1'b0, REG_SWITCH_CONFIGURATION, 32'h0, 32'h0000_0001},
      '{1'b0, 8'h02, 32'h0, 32'h0},
      '{1'b1, REG_REFERENCE_CLOCK_DIVIDER, 32'hffff_0007, 32'h0},
      '{1'b0, REG_REFERENCE_CLOCK_DIVIDER, 32'h0, 32'h0000_0007}};

   node_config_registers #(.SWITCH_REVISION(REV), .SWITCH_VERSION(VER),
      .LINK_COUNT(LINKS), .SWITCH_CORES(SW_CORES),
      .DEVICE_CORES(DEV_CORES)) uut (
      .ref_clk(ref_clk), .reset(reset), .cfg_valid(cfg_valid),
      .cfg_request(cfg_request), .cfg_ack(cfg_ack),
      .cfg_read_data(cfg_read_data), .boot_select_pins(boot_select_pins),
      .clkgen_settings(clkgen_settings), .clkgen_update(clkgen_update),
      .tile_reset_request(tile_reset_request),
      .one_byte_headers(one_byte_headers),
      .node_identifier(node_identifier),
      .switch_clock_divider(switch_clock_divider),
      .reference_clock_divider(reference_clock_divider));

   cfg_access_master tile_side (.ref_clk(ref_clk), .cfg_valid(cfg_valid),
      .cfg_request(cfg_request), .cfg_ack(cfg_ack),
      .cfg_read_data(cfg_read_data));

   // Expected clock settings straight from the field positions
   function automatic clkgen_settings_t settings_of(logic [31:0] d);
      return '{d[30], d[29], d[28], d[25:23], d[20:8], d[6:0]};
   endfunction

   // One access through the tile model; every access must be answered
   task automatic acc(input logic w, input logic [7:0] n,
         input logic [31:0] d);
      tile_side.access(w, n, d, rd, ack);
      `CHECK("ack", 1'b1, ack);
   endtask

   task automatic give_verdict();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Whole run is under fifty cycles; this cuts a hang short
   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      give_verdict();
   end

   initial begin
      reset = 1'b1;
      boot_select_pins = BOOT;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      `CHECK("headers", 1'b0, one_byte_headers);
      `CHECK("node id", 16'h0000, node_identifier);
      `CHECK("switch div", 16'h0000, switch_clock_divider);
      `CHECK("ref div", 16'h0003, reference_clock_divider);
      `CHECK("tile reset", 1'b0, tile_reset_request);
      foreach (rows[i]) begin
         acc(rows[i].write, rows[i].number, rows[i].data);
         `CHECK("read", rows[i].expect_data, rd);
      end
      `CHECK("node id", 16'h1234, node_identifier);
      `CHECK("switch div", 16'h8001, switch_clock_divider);
      `CHECK("headers", 1'b1, one_byte_headers);
      `CHECK("ref div", 16'h0007, reference_clock_divider);
      // Clock settings write without suppression resets the tile
      acc(1'b1, REG_CLOCK_GENERATOR_SETTINGS, 32'h0000_0103);
      `CHECK("update", 1'b1, clkgen_update);
      `CHECK("tile reset", 1'b1, tile_reset_request);
      `CHECK("settings", settings_of(32'h103), clkgen_settings);
      // Back to back: suppression, relock skip, bypass, test boot
      acc(1'b1, REG_CLOCK_GENERATOR_SETTINGS, 32'hf380_0000);
      `CHECK("update", 1'b1, clkgen_update);
      `CHECK("tile reset", 1'b0, tile_reset_request);
      `CHECK("settings", settings_of(32'hf380_0000), clkgen_settings);
      `CHECK("bypass", 1'b1, clkgen_settings.bypass);
      acc(1'b0, REG_CLOCK_GENERATOR_SETTINGS, 32'h0);
      `CHECK("settings read", 32'hf380_0000, rd);
      `CHECK("update", 1'b0, clkgen_update);
      // Clock settings lock drops the write silently
      acc(1'b1, REG_SWITCH_CONFIGURATION, 32'h0000_0100);
      acc(1'b1, REG_CLOCK_GENERATOR_SETTINGS, 32'h0000_0205);
      `CHECK("update", 1'b0, clkgen_update);
      acc(1'b0, REG_CLOCK_GENERATOR_SETTINGS, 32'h0);
      `CHECK("settings read", 32'hf380_0000, rd);
      // Control lock: other registers refuse, configuration can unlock
      acc(1'b1, REG_SWITCH_CONFIGURATION, 32'h8000_0000);
      acc(1'b1, REG_NODE_IDENTIFIER, 32'h0000_beef);
      acc(1'b1, REG_CLOCK_GENERATOR_SETTINGS, 32'h0000_0205);
      `CHECK("update", 1'b0, clkgen_update);
      acc(1'b0, REG_NODE_IDENTIFIER, 32'h0);
      `CHECK("node id read", 32'h0000_1234, rd);
      acc(1'b1, REG_SWITCH_CONFIGURATION, 32'h0000_0000);
      acc(1'b1, REG_NODE_IDENTIFIER, 32'h0000_beef);
      `CHECK("headers", 1'b0, one_byte_headers);
      acc(1'b0, REG_NODE_IDENTIFIER, 32'h0);
      `CHECK("node id read", 32'h0000_beef, rd);
      // Boot pins move after capture; the captured levels must stay
      boot_select_pins = 8'h3c;
      acc(1'b0, REG_DEVICE_IDENTIFICATION, 32'h0);
      `CHECK("ident", IDENT, rd);
      tile_side.release_bus();
      @(negedge ref_clk);
      `CHECK("idle ack", 1'b0, cfg_ack);
      `CHECK("idle data", 32'h0, cfg_read_data);
      // Reset in mid-run: settings return, pins are caught afresh
      reset = 1'b1;
      @(negedge ref_clk);
      reset = 1'b0;
      `CHECK("node id", 16'h0000, node_identifier);
      `CHECK("switch div", 16'h0000, switch_clock_divider);
      `CHECK("settings", settings_of(CLKGEN_RESET), clkgen_settings);
      acc(1'b0, REG_DEVICE_IDENTIFICATION, 32'h0);
      `CHECK("ident", {8'h00, 8'h3c, REV, VER}, rd);
      give_verdict();
   end
endmodule // node_config_registers_test
`undef CHECK
`default_nettype wire
